// [hw/immediate_shift_mem_move.sv]
/*
  Execution of the immediate-shift instruction family with optional
  post-modify memory transfer, single or dual element, with broadcast read.
  Assumes an AHB-Lite master loads state and issues instructions, and a
  memory that answers mem_cmd.req with a one-cycle mem_ack.
*/
`timescale 1ns/100ps
`default_nettype none
module immediate_shift_mem_move (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output imm_shift_pkg::mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata_x,
  input wire logic [31:0] mem_rdata_y
);

  localparam int DW = imm_shift_pkg::DATA_W;

  function automatic logic cond_true(input logic [4:0] cond,
                                     input logic [30:0] flags);
    if (cond == imm_shift_pkg::COND_ALWAYS)
    begin
      cond_true = 1'b1;
    end
    else
    begin
      cond_true = flags[cond];
    end
  endfunction

  function automatic logic [31:0] k_offset(input logic [1:0] width);
    case (width)
      imm_shift_pkg::WIDTH_SHORT: k_offset = imm_shift_pkg::K_SHORT;
      imm_shift_pkg::WIDTH_BYTE: k_offset = imm_shift_pkg::K_BYTE;
      default: k_offset = imm_shift_pkg::K_NORMAL;
    endcase
  endfunction

  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_word;

  ahb_reg_port u_port (
    .sys_clk(sys_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_word(rd_word),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  imm_shift_pkg::instr_type instr_reg;
  imm_shift_pkg::instr_type instr_next;
  imm_shift_pkg::mode_type primary_mode_control_reg;
  imm_shift_pkg::mode_type primary_mode_control_next;
  imm_shift_pkg::mem_cmd_type mem_cmd_reg;
  imm_shift_pkg::mem_cmd_type mem_cmd_next;
  imm_shift_pkg::state_type state_reg;
  imm_shift_pkg::state_type state_next;
  logic [11:0] imm_reg;
  logic [11:0] imm_next;
  logic [30:0] flags_x_reg;
  logic [30:0] flags_x_next;
  logic [30:0] flags_y_reg;
  logic [30:0] flags_y_next;
  logic ex_x_reg;
  logic ex_x_next;
  logic ex_y_reg;
  logic ex_y_next;
  logic bcst_reg;
  logic bcst_next;
  logic [DW-1:0] dag_idx_reg [imm_shift_pkg::DAG_REGS];
  logic [DW-1:0] dag_idx_next [imm_shift_pkg::DAG_REGS];
  logic [DW-1:0] dag_mod_reg [imm_shift_pkg::DAG_REGS];
  logic [DW-1:0] dag_mod_next [imm_shift_pkg::DAG_REGS];
  logic [DW-1:0] rf_x_reg [imm_shift_pkg::RF_DEPTH];
  logic [DW-1:0] rf_x_next [imm_shift_pkg::RF_DEPTH];
  logic [DW-1:0] rf_y_reg [imm_shift_pkg::RF_DEPTH];
  logic [DW-1:0] rf_y_next [imm_shift_pkg::RF_DEPTH];

  // Shifter per element; the shift sees register values from before
  // the memory load of the same instruction
  logic [DW-1:0] sh_in [2];
  logic [DW-1:0] sh_out [2];

  assign sh_in[0] = rf_x_reg[instr_reg.src];
  assign sh_in[1] = rf_y_reg[instr_reg.src];

  genvar pe;
  generate
    for (pe = 0; pe < 2; pe++)
    begin : g_pe
      imm_shifter #(
        .WIDTH(DW)
      ) u_shift (
        .op(instr_reg.shift_op),
        .imm(imm_reg),
        .operand(sh_in[pe]),
        .result(sh_out[pe])
      );
    end
  endgenerate

  logic [7:0] rd_low;

  // Register read mux for the address phase
  always_comb
  begin
    rd_low = haddr[7:0];
    rd_word = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      case (haddr[7:6])
        imm_shift_pkg::REGION_CTRL:
        begin
          case (rd_low)
            imm_shift_pkg::OFF_INSTR: rd_word = instr_reg;
            imm_shift_pkg::OFF_IMM: rd_word = {20'h0_0000, imm_reg};
            imm_shift_pkg::OFF_MODE: rd_word = primary_mode_control_reg;
            imm_shift_pkg::OFF_FLAGS_X: rd_word = {1'b0, flags_x_reg};
            imm_shift_pkg::OFF_FLAGS_Y: rd_word = {1'b0, flags_y_reg};
            imm_shift_pkg::OFF_STATUS:
              rd_word = {29'h0000_0000, ex_y_reg, ex_x_reg,
                state_reg == imm_shift_pkg::ST_WAIT_MEM};
            default: rd_word = 32'h0000_0000;
          endcase
        end
        imm_shift_pkg::REGION_DAG:
          rd_word = haddr[5] ? dag_mod_reg[haddr[4:2]] :
            dag_idx_reg[haddr[4:2]];
        imm_shift_pkg::REGION_RF_X: rd_word = rf_x_reg[haddr[5:2]];
        default: rd_word = rf_y_reg[haddr[5:2]];
      endcase
    end
  end

  imm_shift_pkg::instr_type ni;
  logic [2:0] dag_sel;
  logic [2:0] mod_sel;
  logic gx;
  logic gy;
  logic is_bcst;

  always_comb
  begin
    instr_next = instr_reg;
    primary_mode_control_next = primary_mode_control_reg;
    mem_cmd_next = mem_cmd_reg;
    state_next = state_reg;
    imm_next = imm_reg;
    flags_x_next = flags_x_reg;
    flags_y_next = flags_y_reg;
    ex_x_next = ex_x_reg;
    ex_y_next = ex_y_reg;
    bcst_next = bcst_reg;
    dag_idx_next = dag_idx_reg;
    dag_mod_next = dag_mod_reg;
    rf_x_next = rf_x_reg;
    rf_y_next = rf_y_reg;
    ni = wr_data;
    // g picks generator bank and space
    dag_sel = {instr_reg.gen_sel, instr_reg.index_sel};
    mod_sel = {instr_reg.gen_sel, instr_reg.modify_sel};
    gx = cond_true(ni.cond, flags_x_reg);
    gy = primary_mode_control_reg.simd && cond_true(ni.cond, flags_y_reg);
    // broadcast bit of index 1 in either generator
    is_bcst = primary_mode_control_reg.simd && (ni.dir == imm_shift_pkg::DIR_READ)
      && (ni.index_sel == imm_shift_pkg::BROADCAST_INDEX_SEL)
      && (ni.gen_sel == imm_shift_pkg::GEN_FIRST ?
        primary_mode_control_reg.broadcast_read_first_gen_bit :
        primary_mode_control_reg.broadcast_read_second_gen_bit);
    case (state_reg)
      imm_shift_pkg::ST_IDLE:
      begin
        // Bus writes land only while idle, so state is stable in flight
        if (wr_en && (wr_addr[31:8] == 24'h00_0000))
        begin
          case (wr_addr[7:6])
            imm_shift_pkg::REGION_CTRL:
            begin
              case (wr_addr[7:0])
                imm_shift_pkg::OFF_INSTR:
                begin
                  instr_next = ni;
                  ex_x_next = gx;
                  ex_y_next = gy;
                  bcst_next = is_bcst;
                  // nothing runs when no element passes
                  if (ni.mem_en && (gx || gy))
                  begin
                    state_next = imm_shift_pkg::ST_WAIT_MEM;
                    mem_cmd_next.req = 1'b1;
                    mem_cmd_next.program_space = ni.gen_sel;
                    mem_cmd_next.write = ni.dir;
                    mem_cmd_next.en_x = gx;
                    mem_cmd_next.en_y = gy;
                    mem_cmd_next.addr_x =
                      dag_idx_reg[{ni.gen_sel, ni.index_sel}];
                    mem_cmd_next.addr_y =
                      dag_idx_reg[{ni.gen_sel, ni.index_sel}] +
                      (is_bcst ? imm_shift_pkg::K_BROADCAST :
                        k_offset(primary_mode_control_reg.access_width));
                    mem_cmd_next.wdata_x = rf_x_reg[ni.mem_reg];
                    mem_cmd_next.wdata_y = rf_y_reg[ni.mem_reg];
                  end
                  else
                  begin
                    state_next = imm_shift_pkg::ST_WAIT_MEM;
                    mem_cmd_next.req = 1'b0;
                  end
                end
                imm_shift_pkg::OFF_IMM: imm_next = wr_data[11:0];
                imm_shift_pkg::OFF_MODE: primary_mode_control_next = wr_data;
                imm_shift_pkg::OFF_FLAGS_X: flags_x_next = wr_data[30:0];
                imm_shift_pkg::OFF_FLAGS_Y: flags_y_next = wr_data[30:0];
                default: ;
              endcase
            end
            imm_shift_pkg::REGION_DAG:
            begin
              if (wr_addr[5])
              begin
                dag_mod_next[wr_addr[4:2]] = wr_data;
              end
              else
              begin
                dag_idx_next[wr_addr[4:2]] = wr_data;
              end
            end
            imm_shift_pkg::REGION_RF_X: rf_x_next[wr_addr[5:2]] = wr_data;
            default: rf_y_next[wr_addr[5:2]] = wr_data;
          endcase
        end
      end
      imm_shift_pkg::ST_WAIT_MEM:
      begin
        if (mem_ack || !mem_cmd_reg.req)
        begin
          state_next = imm_shift_pkg::ST_IDLE;
          mem_cmd_next.req = 1'b0;
          mem_cmd_next.en_x = 1'b0;
          mem_cmd_next.en_y = 1'b0;
          if (ex_x_reg)
          begin
            rf_x_next[instr_reg.dst] = sh_out[0];
          end
          if (ex_y_reg)
          begin
            rf_y_next[instr_reg.dst] = sh_out[1];
          end
          if (mem_cmd_reg.req)
          begin
            dag_idx_next[dag_sel] = dag_idx_reg[dag_sel] +
              dag_mod_reg[mod_sel];
            if (instr_reg.dir == imm_shift_pkg::DIR_READ)
            begin
              if (ex_x_reg)
              begin
                rf_x_next[instr_reg.mem_reg] = mem_rdata_x;
              end
              if (ex_y_reg)
              begin
                rf_y_next[instr_reg.mem_reg] =
                  bcst_reg ? mem_rdata_x : mem_rdata_y;
              end
            end
          end
        end
      end
      default: state_next = imm_shift_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      instr_reg <= imm_shift_pkg::WORD_RESET;
      primary_mode_control_reg <= imm_shift_pkg::WORD_RESET;
      mem_cmd_reg <= '0;
      state_reg <= imm_shift_pkg::ST_IDLE;
      imm_reg <= imm_shift_pkg::IMM_RESET;
      flags_x_reg <= imm_shift_pkg::FLAGS_RESET;
      flags_y_reg <= imm_shift_pkg::FLAGS_RESET;
      ex_x_reg <= 1'b0;
      ex_y_reg <= 1'b0;
      bcst_reg <= 1'b0;
      for (int i = 0; i < imm_shift_pkg::DAG_REGS; i++)
      begin
        dag_idx_reg[i] <= imm_shift_pkg::WORD_RESET;
        dag_mod_reg[i] <= imm_shift_pkg::WORD_RESET;
      end
      for (int i = 0; i < imm_shift_pkg::RF_DEPTH; i++)
      begin
        rf_x_reg[i] <= imm_shift_pkg::WORD_RESET;
        rf_y_reg[i] <= imm_shift_pkg::WORD_RESET;
      end
    end
    else
    begin
      instr_reg <= instr_next;
      primary_mode_control_reg <= primary_mode_control_next;
      mem_cmd_reg <= mem_cmd_next;
      state_reg <= state_next;
      imm_reg <= imm_next;
      flags_x_reg <= flags_x_next;
      flags_y_reg <= flags_y_next;
      ex_x_reg <= ex_x_next;
      ex_y_reg <= ex_y_next;
      bcst_reg <= bcst_next;
      dag_idx_reg <= dag_idx_next;
      dag_mod_reg <= dag_mod_next;
      rf_x_reg <= rf_x_next;
      rf_y_reg <= rf_y_next;
    end
  end

  assign mem_cmd = mem_cmd_reg;

endmodule
`default_nettype wire

// [hw/imm_shift_pkg.sv]
/*
  Shared constants and types for the immediate-shift / memory-move
  execution block: register map, field layouts, encodings, reset values.
  Assumes a 32-bit AHB-Lite register bus and a 32-bit memory port.
*/
package imm_shift_pkg;

  localparam int DATA_W = 32;
  localparam int RF_DEPTH = 16;
  localparam int DAG_REGS = 8;

  // Condition code that means "always"
  localparam logic [4:0] COND_ALWAYS = 5'h1F;

  // Control region word offsets (byte addresses, low byte)
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_IMM = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_FLAGS_X = 8'h0C;
  localparam logic [7:0] OFF_FLAGS_Y = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Regions selected by address bits 7:6
  localparam logic [1:0] REGION_CTRL = 2'h0;
  localparam logic [1:0] REGION_DAG = 2'h1;
  localparam logic [1:0] REGION_RF_X = 2'h2;
  localparam logic [1:0] REGION_RF_Y = 2'h3;

  // Access width field of the mode register
  localparam logic [1:0] WIDTH_NORMAL = 2'h0;
  localparam logic [1:0] WIDTH_SHORT = 2'h1;
  localparam logic [1:0] WIDTH_BYTE = 2'h2;

  // Secondary element address offsets
  localparam logic [31:0] K_NORMAL = 32'h0000_0001;
  localparam logic [31:0] K_SHORT = 32'h0000_0002;
  localparam logic [31:0] K_BYTE = 32'h0000_0004;
  localparam logic [31:0] K_BROADCAST = 32'h0000_0000;

  // Shifter operations
  localparam logic [1:0] SHOP_LSHIFT = 2'h0;
  localparam logic [1:0] SHOP_ASHIFT = 2'h1;
  localparam logic [1:0] SHOP_ROT = 2'h2;
  localparam logic [1:0] SHOP_FEXT = 2'h3;

  // Access field encodings
  localparam logic GEN_FIRST = 1'b0;
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  // Index select that owns the broadcast bit in each generator
  localparam logic [1:0] BROADCAST_INDEX_SEL = 2'h1;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [11:0] IMM_RESET = 12'h000;
  localparam logic [30:0] FLAGS_RESET = 31'h0000_0000;

  typedef struct packed {
    logic [4:0] cond;
    logic mem_en;
    logic gen_sel;
    logic dir;
    logic [3:0] mem_reg;
    logic [1:0] index_sel;
    logic [1:0] modify_sel;
    logic [3:0] dst;
    logic [3:0] src;
    logic [1:0] shift_op;
    logic [5:0] spare;
  } instr_type;

  typedef struct packed {
    logic [26:0] spare;
    logic [1:0] access_width;
    logic broadcast_read_second_gen_bit;
    logic broadcast_read_first_gen_bit;
    logic simd;
  } mode_type;

  typedef struct packed {
    logic req;
    logic program_space;
    logic write;
    logic en_x;
    logic en_y;
    logic [31:0] addr_x;
    logic [31:0] addr_y;
    logic [31:0] wdata_x;
    logic [31:0] wdata_y;
  } mem_cmd_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT_MEM = 1'b1
  } state_type;

endpackage

// [hw/imm_shifter.sv]
/*
  Immediate shifter for one processing element: shift, arithmetic shift,
  rotate by a signed 8-bit immediate, or field extract by two 6-bit values.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
`default_nettype none
module imm_shifter #(
  parameter int WIDTH = 32
) (
  input wire logic [1:0] op,
  input wire logic [11:0] imm,
  input wire logic [WIDTH-1:0] operand,
  output logic [WIDTH-1:0] result
);

  // Rotate and field masks assume a 32-bit word
  if (WIDTH != 32)
  begin : g_width_chk
    $error("imm_shifter supports WIDTH 32 only");
  end

  logic [7:0] mag;
  logic [4:0] rot_amt;
  logic [5:0] len;
  logic [WIDTH-1:0] mask;

  always_comb
  begin
    mag = imm[7] ? 8'(~imm[7:0] + 8'h01) : imm[7:0];
    rot_amt = imm[7] ? 5'(6'h20 - {1'b0, mag[4:0]}) : mag[4:0];
    len = imm[11:6];
    mask = (len >= 6'h20) ? {WIDTH{1'b1}} :
      WIDTH'((33'h1 << len) - 33'h1);
    case (op)
      imm_shift_pkg::SHOP_LSHIFT:
        result = imm[7] ? (operand >> mag) : (operand << mag);
      imm_shift_pkg::SHOP_ASHIFT:
        result = imm[7] ? WIDTH'($signed(operand) >>> mag) :
          (operand << mag);
      imm_shift_pkg::SHOP_ROT:
        result = (operand << rot_amt) |
          (operand >> (6'h20 - {1'b0, rot_amt}));
      imm_shift_pkg::SHOP_FEXT:
        result = (operand >> imm[5:0]) & mask;
      default:
        result = operand;
    endcase
  end

endmodule
`default_nettype wire

// [hw/ahb_reg_port.sv]
/*
  Zero-wait AHB-Lite slave front end: turns bus transfers into a one-cycle
  write strobe and a registered read word. Assumes single word transfers.
*/
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] rd_word,
  output logic wr_en,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data
);

  logic take;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb
  begin
    // Only whole words are served; narrower sizes are ignored
    take = hsel && htrans[1] && hready && (hsize == 3'h2);
    wr_pend_next = take && hwrite;
    addr_next = take ? haddr : addr_reg;
    rdata_next = (take && !hwrite) ? rd_word : rdata_reg;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign wr_en = wr_pend_reg;
  assign wr_addr = addr_reg;
  assign wr_data = hwdata;

endmodule
`default_nettype wire

// [sim/immediate_shift_mem_move_chk.sv]
/*
  Port checker for the shift/move block: memory request timing, space,
  direction, element enables and secondary addressing.
  Assumes it is bound to the top and the bus writes whole words.
*/
`timescale 1ns/100ps
`default_nettype none
module immediate_shift_mem_move_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire imm_shift_pkg::mem_cmd_type mem_cmd,
  input wire logic mem_ack
);
  logic wp_reg;
  logic [7:0] wa_reg;
  imm_shift_pkg::instr_type ins_reg;
  imm_shift_pkg::mode_type mode_reg;
  logic ins_dp;
  logic bcast;
  logic [31:0] k;
  assign ins_dp = wp_reg && wa_reg == imm_shift_pkg::OFF_INSTR;
  assign bcast = ins_reg.index_sel == 2'h1 && (ins_reg.gen_sel ?
    mode_reg.broadcast_read_second_gen_bit :
    mode_reg.broadcast_read_first_gen_bit);
  // Width 3 is served as normal words
  assign k = mode_reg.access_width == 2'h1 ? 32'h2 :
    mode_reg.access_width == 2'h2 ? 32'h4 : 32'h1;
  // Shadow of the last instruction and mode words written
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_reg <= 1'b0;
      wa_reg <= 8'h00;
      ins_reg <= '0;
      mode_reg <= '0;
    end
    else
    begin
      wp_reg <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2
        && haddr[31:8] == 24'h000000;
      wa_reg <= haddr[7:0];
      if (ins_dp)
        ins_reg <= hwdata;
      if (wp_reg && wa_reg == imm_shift_pkg::OFF_MODE)
        mode_reg <= hwdata;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_issue;
    $rose(mem_cmd.req);
  endsequence
  sequence s_wait;
    mem_cmd.req && !mem_ack;
  endsequence
  AST_NOMEM_QUIET: assert property (
    ins_dp && !hwdata[26] |=> !mem_cmd.req [*3])
    else $error("memory request from a no-memory instruction");
  AST_ALWAYS_RUNS: assert property (
    ins_dp && hwdata[26] && hwdata[31:27] == 5'h1F |=> mem_cmd.req && mem_cmd.en_x)
    else $error("unconditional transfer not started");
  AST_START_CAUSE: assert property (
    s_issue |-> $past(ins_dp))
    else $error("memory request without an instruction");
  AST_HOLD: assert property (
    s_wait |=> mem_cmd.req && $stable(mem_cmd))
    else $error("memory command changed before ack");
  AST_DROP: assert property (
    mem_cmd.req && mem_ack |=> !mem_cmd.req)
    else $error("memory request held after ack");
  AST_SPACE_DIR: assert property (
    s_issue |-> mem_cmd.program_space == ins_reg.gen_sel
      && mem_cmd.write == ins_reg.dir)
    else $error("wrong space or direction");
  AST_SINGLE_ELEMENT_MODE_NO_Y: assert property (
    s_issue and !mode_reg.simd |-> !mem_cmd.en_y)
    else $error("secondary element active in single mode");
  AST_SIMD_Y: assert property (
    s_issue and mode_reg.simd && ins_reg.cond == 5'h1F |-> mem_cmd.en_y)
    else $error("secondary element idle in dual mode");
  AST_K_OFFSET: assert property (
    s_issue and mode_reg.simd && (ins_reg.dir || !bcast)
      |-> mem_cmd.addr_y == mem_cmd.addr_x + k)
    else $error("secondary address offset wrong");
  AST_BCAST_ADDR: assert property (
    s_issue and mode_reg.simd && bcast && !ins_reg.dir
      |-> mem_cmd.addr_y == mem_cmd.addr_x)
    else $error("broadcast read address differs");
endmodule
`default_nettype wire

// [sim/mem_partner.sv]
/*
  Behavioural memory on the far side of mem_cmd: acks after a chosen
  number of cycles and keeps the last accepted command for the bench.
  Assumes req stays up until the cycle after the ack.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire imm_shift_pkg::mem_cmd_type mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata_x,
  output logic [31:0] mem_rdata_y,
  output imm_shift_pkg::mem_cmd_type last_cmd,
  output logic [7:0] acc_cnt
);
  logic [3:0] wait_reg;
  // Data is inverted outside the ack so an early sample is caught
  assign mem_rdata_x = {32{!mem_ack}} ^ mem_cmd.addr_x ^ 32'hA5A5_0000;
  assign mem_rdata_y = {32{!mem_ack}} ^ mem_cmd.addr_y ^ 32'h5A5A_0000;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      last_cmd <= '0;
      acc_cnt <= 8'h00;
    end
    else if (mem_cmd.req && !mem_ack)
    begin
      if (wait_reg == delay)
      begin
        mem_ack <= 1'b1;
        last_cmd <= mem_cmd;
        acc_cnt <= acc_cnt + 8'h01;
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
    else
    begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// [sim/immediate_shift_mem_move_tb.sv]
/*
  Self-checking bench: loads state over AHB-Lite, issues instructions,
  checks memory commands and register results.
  Assumes the zero-wait slave and the register map of the block.
*/
`timescale 1ns/100ps
`default_nettype none
module immediate_shift_mem_move_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] delay = 4'h0;
  logic hreadyout, hresp, mem_ack;
  logic [31:0] hrdata, mem_rdata_x, mem_rdata_y;
  logic [7:0] acc_cnt;
  imm_shift_pkg::mem_cmd_type mem_cmd, last_cmd;
  int failures = 0;
  int n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  immediate_shift_mem_move dut_u (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata_x(mem_rdata_x),
    .mem_rdata_y(mem_rdata_y));
  mem_partner mem_u (.sys_clk(sys_clk), .rst(rst), .delay(delay),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata_x(mem_rdata_x),
    .mem_rdata_y(mem_rdata_y), .last_cmd(last_cmd), .acc_cnt(acc_cnt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Polling is bounded; a stuck busy counts as a mismatch
  task automatic run(input logic [31:0] ins);
    logic [31:0] q;
    int n;
    wr(32'h00, ins);
    n = 0;
    do
    begin
      bus(1'b0, 32'h14, 32'h0, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 100);
    if (n >= 100)
      failures++;
  endtask
  // Source register 6, left shift by the immediate
  function automatic logic [31:0] mk(input logic [4:0] c,
    input logic [2:0] mgd, input logic [3:0] mr, input logic [3:0] sel,
    input logic [3:0] dst);
    return {c, mgd, mr, sel, dst, 4'h6, 2'h0, 6'h00};
  endfunction
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    failures++;
    wrap_up();
  end
  initial
  begin
    logic [31:0] a;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wr(32'h04, 32'h4);
    wr(32'h98, 32'h1234);
    wr(32'hD8, 32'hABC);
    wr(32'h80, 32'hCAFE0001);
    wr(32'hC0, 32'hBEEF0002);
    wr(32'h40, 32'h100);
    wr(32'h60, 32'h3);
    rchk(32'h18, 32'h0);
    run(mk(5'h1F, 3'h0, 4'h0, 4'h0, 4'h2));
    rchk(32'h88, 32'h12340);
    rchk(32'h40, 32'h100);
    chk({24'h0, acc_cnt}, 32'h0);
    delay <= 4'h3;
    run(mk(5'h1F, 3'h5, 4'h0, 4'h0, 4'h3));
    chk(last_cmd.addr_x, 32'h100);
    chk(last_cmd.wdata_x, 32'hCAFE0001);
    chk({28'h0, last_cmd[131:128]}, 32'h6);
    rchk(32'h40, 32'h103);
    rchk(32'h8C, 32'h12340);
    wr(32'h0C, 32'h0);
    run(mk(5'h05, 3'h5, 4'h0, 4'h0, 4'h4));
    chk({24'h0, acc_cnt}, 32'h1);
    rchk(32'h90, 32'h0);
    rchk(32'h40, 32'h103);
    wr(32'h0C, 32'h20);
    run(mk(5'h05, 3'h0, 4'h0, 4'h0, 4'h4));
    rchk(32'h90, 32'h12340);
    wr(32'h50, 32'h200);
    wr(32'h70, 32'h1);
    for (int w = 0; w < 3; w++)
    begin
      wr(32'h08, (w << 3) | 1);
      delay <= w[3:0];
      run(mk(5'h1F, 3'h6, 4'h8, 4'h0, 4'h5));
      a = 32'h200 + w;
      chk(last_cmd.addr_y, a + (1 << w));
      chk({28'h0, last_cmd[131:128]}, 32'hB);
      rchk(32'hA0, a ^ 32'hA5A5_0000);
      rchk(32'hE0, (a + (1 << w)) ^ 32'h5A5A_0000);
      rchk(32'h94, 32'h12340);
      rchk(32'hD4, 32'hABC0);
      rchk(32'h50, a + 1);
    end
    wr(32'h08, 32'h1);
    wr(32'h0C, 32'h0);
    wr(32'h10, 32'h20);
    run(mk(5'h05, 3'h5, 4'h0, 4'h0, 4'h9));
    chk({30'h0, last_cmd.en_x, last_cmd.en_y}, 32'h1);
    chk(last_cmd.addr_y, 32'h104);
    chk(last_cmd.wdata_y, 32'hBEEF0002);
    rchk(32'hA4, 32'h0);
    rchk(32'hE4, 32'hABC0);
    rchk(32'h40, 32'h106);
    wr(32'h08, 32'h3);
    wr(32'h44, 32'h300);
    wr(32'h64, 32'h2);
    run(mk(5'h1F, 3'h4, 4'hA, 4'h5, 4'hB));
    chk(last_cmd.addr_y, 32'h300);
    rchk(32'hA8, 32'h300 ^ 32'hA5A5_0000);
    rchk(32'hE8, 32'h300 ^ 32'hA5A5_0000);
    rchk(32'h44, 32'h302);
    wr(32'h08, 32'h5);
    run(mk(5'h1F, 3'h6, 4'hE, 4'h4, 4'hF));
    chk(last_cmd.addr_y, 32'h0);
    rchk(32'hF8, 32'hA5A5_0000);
    wr(32'h04, 32'h204);
    run(mk(5'h1F, 3'h0, 4'h0, 4'h0, 4'hC) | 32'hC0);
    rchk(32'hB0, 32'h23);
    rchk(32'hF0, 32'hAB);
    wr(32'h04, 32'hFC);
    run(mk(5'h1F, 3'h0, 4'h0, 4'h0, 4'hD) | 32'h40);
    rchk(32'hB4, 32'h123);
    wrap_up();
  end
endmodule
bind immediate_shift_mem_move immediate_shift_mem_move_chk chk_u (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .mem_cmd(mem_cmd), .mem_ack(mem_ack));
`default_nettype wire
